// ===== hdl/spc_params.svh
// Serial port configuration constants: offsets, fields, reset values
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_ADDR_CFG 13'h0000
`define SPC_ADDR_RDSEL 13'h0004
`define SPC_ADDR_VER_LO 13'h0005
`define SPC_ADDR_VER_HI 13'h0006
`define SPC_ADDR_DIV_LO 13'h0010
`define SPC_ADDR_DIV_HI 13'h0011
`define SPC_CFG_DIR_BIT 7
`define SPC_CFG_LSB_BIT 6
`define SPC_CFG_SRST_BIT 5
`define SPC_INSTR_RW_BIT 15
`define SPC_INSTR_LAST 4'hF
`define SPC_BYTE_LAST 4'h7
`define SPC_RST_DIR 1'b0
`define SPC_RST_LSB 1'b0
`define SPC_RST_RDSEL 1'b0
`define SPC_RST_VER 8'h00
`define SPC_RST_DIV 10'h000
`endif

// ===== hdl/spc_pkg.sv
// Types shared by the serial port configuration block
package spc_pkg;
  typedef enum logic {SPC_INSTR, SPC_DATA} spc_state_e;
  typedef struct packed {
    logic csbN;
    logic sclk;
    logic sdio;
  } spc_link_s;
  typedef logic [12:0] spc_addr_t;
endpackage

// ===== hdl/spc_serial_port_config.sv
// Serial port configuration registers with SPI slave and reference divider
`timescale 1ns/100ps
`default_nettype none
`include "spc_params.svh"
//
// Overview of operation
// R1: Direction bit 0: bidirectional pin, output pin off
// R2: Direction bit 1: reads driven on output pin
// R3: Order bit 0: MSB first, address decrements
// R4: Order bit 1: LSB first, address increments
// R5: I2C mode ignores direction and order bits
// R6: Soft reset bit restores defaults, self clears
// R7: Host mirrors high nibble into low nibble
// R8: Readback select 0 returns active values
// R9: Readback select 1 returns buffered pending values
// R10: 16-bit version ID at 0x005/0x006, default zero
// R11: Version ID affects no device behaviour
// R12: Ten-bit divider split over 0x010 and 0x011
// R13: Divider 0 or 1 divides by one
// R14: Reserved bits read zero, writes ignored
module spc_serial_port_config
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire spc_link_s link,
  input wire logic i2cMode,
  input wire logic ioUpdate,
  input wire logic refIn,
  output logic sdioOut_r,
  output logic sdioOe_r,
  output logic serialOutPin_r,
  output logic serialOutPinOe_r,
  output logic refDivPulse_r
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] syncA_r;
  logic [5:0] syncB_r;
  logic sclkPrev_r;
  logic refPrev_r;
  logic updPrev_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA_r <= 6'h20; // Idle pin levels, so no false edge follows reset
      syncB_r <= 6'h20;
      sclkPrev_r <= 1'b0;
      refPrev_r <= 1'b0;
      updPrev_r <= 1'b0;
    end
    else
    begin
      syncA_r <= {link.csbN, link.sclk, link.sdio, i2cMode, ioUpdate, refIn};
      syncB_r <= syncA_r;
      sclkPrev_r <= syncB_r[4];
      refPrev_r <= syncB_r[0];
      updPrev_r <= syncB_r[1];
    end
  end

  wire csbS = syncB_r[5];
  wire sclkS = syncB_r[4];
  wire sdioS = syncB_r[3];
  wire i2cS = syncB_r[2];
  wire updEdge = syncB_r[1] & ~updPrev_r;
  wire refEdge = syncB_r[0] & ~refPrev_r;

  // ****************************************
  // Registers and decode
  // ****************************************
  logic dirBit_r;
  logic lsbBit_r;
  logic rdSel_r;
  logic [7:0] verLo_r;
  logic [7:0] verHi_r;
  logic [9:0] divBuf_r;
  logic [9:0] divAct_r;
  spc_state_e state_r;
  logic [15:0] shift_r;
  logic [3:0] bitCnt_r;
  logic rd_r;
  spc_addr_t addr_r;

  wire dirEff = dirBit_r & ~i2cS; // R5
  wire lsbEff = lsbBit_r & ~i2cS; // R5
  wire spiActive = ~csbS & ~i2cS;
  wire sclkRise = sclkS & ~sclkPrev_r & spiActive;
  wire sclkFall = ~sclkS & sclkPrev_r & spiActive;
  wire [15:0] shiftNxt = {shift_r[14:0], sdioS};
  wire [15:0] instrWord = lsbEff ? {rev8(shiftNxt[7:0]), rev8(shiftNxt[15:8])} : shiftNxt; // R4
  wire [7:0] byteVal = lsbEff ? rev8(shiftNxt[7:0]) : shiftNxt[7:0]; // R3 R4
  wire instrDone = sclkRise && state_r == SPC_INSTR && bitCnt_r == `SPC_INSTR_LAST;
  wire byteDone = sclkRise && state_r == SPC_DATA && bitCnt_r == `SPC_BYTE_LAST;
  wire wrStrobe = byteDone && !rd_r;
  wire softRst = wrStrobe && addr_r == `SPC_ADDR_CFG && byteVal[`SPC_CFG_SRST_BIT]; // R6
  wire spc_addr_t addrStep = lsbEff ? addr_r + 13'h0001 : addr_r - 13'h0001; // R3 R4
  wire [9:0] divRead = rdSel_r ? divBuf_r : divAct_r; // R8 R9
  // Soft reset bit always reads zero; low nibble shows the mirror
  wire [7:0] cfgRead = {dirBit_r, lsbBit_r, 2'b00, 2'b00, lsbBit_r, dirBit_r};
  wire [7:0] readData =
    addr_r == `SPC_ADDR_CFG ? cfgRead :
    addr_r == `SPC_ADDR_RDSEL ? {7'h00, rdSel_r} : // R14
    addr_r == `SPC_ADDR_VER_LO ? verLo_r : // R10
    addr_r == `SPC_ADDR_VER_HI ? verHi_r : // R10
    addr_r == `SPC_ADDR_DIV_LO ? divRead[7:0] : // R12
    addr_r == `SPC_ADDR_DIV_HI ? {6'h00, divRead[9:8]} : // R12 R14
    8'h00;
  wire [2:0] bitIdx = lsbEff ? bitCnt_r[2:0] : 3'h7 - bitCnt_r[2:0]; // R3 R4

  // ****************************************
  // Register file
  // ****************************************
  // Version ID is stored only; nothing below reads it but the readback
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dirBit_r <= `SPC_RST_DIR;
      lsbBit_r <= `SPC_RST_LSB;
      rdSel_r <= `SPC_RST_RDSEL;
      verLo_r <= `SPC_RST_VER;
      verHi_r <= `SPC_RST_VER;
      divBuf_r <= `SPC_RST_DIV;
      divAct_r <= `SPC_RST_DIV;
    end
    else if (softRst) // R6
    begin
      dirBit_r <= `SPC_RST_DIR;
      lsbBit_r <= `SPC_RST_LSB;
      rdSel_r <= `SPC_RST_RDSEL;
      verLo_r <= `SPC_RST_VER;
      verHi_r <= `SPC_RST_VER;
      divBuf_r <= `SPC_RST_DIV;
      divAct_r <= `SPC_RST_DIV;
    end
    else
    begin
      if (wrStrobe && addr_r == `SPC_ADDR_CFG)
      begin
        dirBit_r <= byteVal[`SPC_CFG_DIR_BIT]; // R1 R2
        lsbBit_r <= byteVal[`SPC_CFG_LSB_BIT]; // R3 R4
      end
      if (wrStrobe && addr_r == `SPC_ADDR_RDSEL)
        rdSel_r <= byteVal[0]; // R14
      if (wrStrobe && addr_r == `SPC_ADDR_VER_LO)
        verLo_r <= byteVal; // R10 R11
      if (wrStrobe && addr_r == `SPC_ADDR_VER_HI)
        verHi_r <= byteVal; // R10 R11
      if (wrStrobe && addr_r == `SPC_ADDR_DIV_LO)
        divBuf_r[7:0] <= byteVal; // R12
      if (wrStrobe && addr_r == `SPC_ADDR_DIV_HI)
        divBuf_r[9:8] <= byteVal[1:0]; // R12 R14
      if (updEdge)
        divAct_r <= divBuf_r; // R9
    end
  end

  // ****************************************
  // SPI slave
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SPC_INSTR;
      shift_r <= 16'h0000;
      bitCnt_r <= 4'h0;
      rd_r <= 1'b0;
      addr_r <= 13'h0000;
    end
    else if (!spiActive)
    begin
      state_r <= SPC_INSTR;
      bitCnt_r <= 4'h0;
    end
    else if (sclkRise)
    begin
      shift_r <= shiftNxt;
      case (state_r)
        SPC_INSTR:
        begin
          bitCnt_r <= instrDone ? 4'h0 : bitCnt_r + 4'h1;
          if (instrDone)
          begin
            state_r <= SPC_DATA;
            rd_r <= instrWord[`SPC_INSTR_RW_BIT];
            addr_r <= instrWord[12:0];
          end
        end
        SPC_DATA:
        begin
          bitCnt_r <= byteDone ? 4'h0 : bitCnt_r + 4'h1;
          if (byteDone)
            addr_r <= addrStep; // R3 R4
        end
        default:
        begin
          state_r <= SPC_INSTR;
          bitCnt_r <= 4'h0;
        end
      endcase
    end
  end

  // Read bits change on the falling edge so the host samples on rising
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sdioOut_r <= 1'b0;
      sdioOe_r <= 1'b0;
      serialOutPin_r <= 1'b0;
      serialOutPinOe_r <= 1'b0;
    end
    else if (!spiActive)
    begin
      sdioOe_r <= 1'b0;
      serialOutPinOe_r <= 1'b0;
    end
    else if (sclkFall && state_r == SPC_DATA && rd_r)
    begin
      sdioOut_r <= readData[bitIdx];
      serialOutPin_r <= readData[bitIdx];
      sdioOe_r <= ~dirEff; // R1
      serialOutPinOe_r <= dirEff; // R2
    end
  end

  // ****************************************
  // Reference input one divider
  // ****************************************
  logic [9:0] divCnt_r;
  wire [9:0] divEff = (divAct_r <= 10'h001) ? 10'h001 : divAct_r; // R13
  wire divWrap = divCnt_r >= divEff - 10'h001;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCnt_r <= 10'h000;
      refDivPulse_r <= 1'b0;
    end
    else
    begin
      refDivPulse_r <= refEdge && divWrap; // R13
      if (refEdge)
        divCnt_r <= divWrap ? 10'h000 : divCnt_r + 10'h001;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_sdio_dir: assert property (@(posedge clk) disable iff (!rst_n) // R1
    $rose(sdioOe_r) |-> $past(!dirEff)) else $error("SDIO driven in unidirectional mode");
  chk_outpin_dir: assert property (@(posedge clk) disable iff (!rst_n) // R2
    serialOutPinOe_r |-> !sdioOe_r && (dirEff || !spiActive || $past(dirEff)))
    else $error("Output pin use does not match direction bit");
  chk_addr_step: assert property (@(posedge clk) disable iff (!rst_n || softRst) // R3
    byteDone |=> addr_r == ($past(lsbEff) ? $past(addr_r) + 13'h0001 : $past(addr_r) - 13'h0001))
    else $error("Address step direction wrong");
  chk_i2c_ignore: assert property (@(posedge clk) disable iff (!rst_n) // R5
    i2cS |-> !dirEff && !lsbEff && !serialOutPinOe_r ##1 !sdioOe_r) else $error("Bit settings used in I2C mode");
  chk_soft_reset: assert property (@(posedge clk) disable iff (!rst_n) // R6
    softRst |=> verLo_r == `SPC_RST_VER && divBuf_r == `SPC_RST_DIV && !dirBit_r && cfgRead[5] == 1'b0)
    else $error("Soft reset did not restore defaults");
  chk_readback_sel: assert property (@(posedge clk) disable iff (!rst_n) // R8
    addr_r == `SPC_ADDR_DIV_LO |-> readData == (rdSel_r ? divBuf_r[7:0] : divAct_r[7:0]))
    else $error("Readback source select wrong");
  chk_update_copy: assert property (@(posedge clk) disable iff (!rst_n || softRst) // R9
    updEdge |=> divAct_r == $past(divBuf_r)) else $error("Update did not apply buffer");
  chk_version_wr: assert property (@(posedge clk) disable iff (!rst_n || softRst) // R10
    wrStrobe && addr_r == `SPC_ADDR_VER_HI |=> verHi_r == $past(byteVal)) else $error("Version ID write lost");
  chk_div_pulse: assert property (@(posedge clk) disable iff (!rst_n) // R13
    refEdge && divWrap |=> refDivPulse_r ##1 (divEff == 10'h001 || !refDivPulse_r))
    else $error("Divider pulse timing wrong");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n) // R14
    addr_r == `SPC_ADDR_DIV_HI |-> readData[7:2] == 6'h00) else $error("Reserved bits not zero");

endmodule
`default_nettype wire

// ===== sim/spc_host_model.sv
// Host controller model for the serial control port
`timescale 1ns/100ps
`default_nettype none
module spc_host_model
  import spc_pkg::*;
(
  input wire logic clk,
  input wire logic sdioOut_r,
  input wire logic sdioOe_r,
  input wire logic serialOutPin_r,
  input wire logic serialOutPinOe_r,
  output spc_link_s link,
  output logic rdValid,
  output logic [7:0] rdByte
);
  logic csbN = 1'b1;
  logic sclk = 1'b0;
  logic drv = 1'b0;
  logic bitOut = 1'b0;
  logic lastSdio = 1'b0;
  logic lastSerialOut = 1'b0;
  wire logic sdioW;
  wire logic serialOutW;
  // Released lines toggle so a stale bit never looks valid
  assign sdioW = sdioOe_r ? sdioOut_r : (drv ? bitOut : ~lastSdio);
  assign serialOutW = serialOutPinOe_r ? serialOutPin_r : ~lastSerialOut;
  assign link = '{csbN: csbN, sclk: sclk, sdio: sdioW};
  initial rdValid = 1'b0;
  initial rdByte = 8'h00;
  always @(posedge clk)
  begin
    lastSdio <= sdioW;
    lastSerialOut <= serialOutW;
  end
  // Link clock period 125 ns; the half-step start keeps its edges clear of clk edges
  task automatic shift(input logic [15:0] v, input int nb, input logic lsb, input logic useSerialOut,
                       output logic [15:0] got);
    got = 16'h0000;
    @(negedge clk);
    #0.5;
    for (int i = 0; i < nb; i++)
    begin
      bitOut = lsb ? v[i] : v[nb-1-i];
      #62;
      sclk = 1'b1;
      got[lsb ? i : nb-1-i] = useSerialOut ? serialOutW : sdioW;
      #63;
      sclk = 1'b0;
    end
  endtask
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd, input int n,
                      input logic lsb, input logic useSerialOut);
    logic [15:0] g;
    @(negedge clk);
    csbN = 1'b0;
    drv = 1'b1;
    repeat (4) @(negedge clk);
    shift({rd, 2'b00, addr}, 16, lsb, useSerialOut, g);
    drv = !rd;
    for (int b = 0; b < n; b++)
    begin
      shift({8'h00, wd}, 8, lsb, useSerialOut, g);
      if (rd)
      begin
        // Byte settles 7.5 ns, just under a clk cycle, before the strobe, so the watcher never races it
        rdByte = g[7:0];
        @(negedge clk);
        rdValid = 1'b1;
        @(negedge clk);
        rdValid = 1'b0;
      end
    end
    repeat (4) @(negedge clk);
    csbN = 1'b1;
    drv = 1'b0;
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ===== sim/test_serial_port_config_regs.sv
// Self-checking bench for the serial port configuration registers
`timescale 1ns/100ps
`default_nettype none
module test_serial_port_config_regs
  import spc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic i2cMode = 1'b0;
  logic ioUpdate = 1'b0;
  logic refIn = 1'b0;
  logic lsbMode = 1'b0;
  logic dirMode = 1'b0;
  logic [7:0] rnd = 8'h45;
  logic [15:0] ver;
  logic [15:0] pulseCnt = 16'h0000;
  logic [15:0] badOe = 16'h0000;
  logic [7:0] expQ[$];
  int nFail = 0;
  int nCompared = 0;
  spc_link_s link;
  wire logic sdioOut, sdioOe, serialOutPin, serialOutPinOe, refDivPulse, rdValid;
  wire logic [7:0] rdByte;
  spc_serial_port_config dut (.clk(clk), .rst_n(rst_n), .link(link), .i2cMode(i2cMode),
    .ioUpdate(ioUpdate), .refIn(refIn), .sdioOut_r(sdioOut), .sdioOe_r(sdioOe),
    .serialOutPin_r(serialOutPin), .serialOutPinOe_r(serialOutPinOe), .refDivPulse_r(refDivPulse));
  spc_host_model host (.clk(clk), .sdioOut_r(sdioOut), .sdioOe_r(sdioOe), .serialOutPin_r(serialOutPin),
    .serialOutPinOe_r(serialOutPinOe), .link(link), .rdValid(rdValid), .rdByte(rdByte));
  initial forever #4 clk = ~clk;
  // ****************
  // Helpers
  // ****************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    nCompared++;
    if (seen !== want)
    begin
      nFail++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic final_report;
    if (nFail == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, 1, lsbMode, dirMode);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.xfer(1'b1, a, 8'h00, 1, lsbMode, dirMode);
  endtask
  task automatic rd2(input logic [12:0] a, input logic [7:0] e0, input logic [7:0] e1);
    expQ.push_back(e0);
    expQ.push_back(e1);
    host.xfer(1'b1, a, 8'h00, 2, lsbMode, dirMode);
  endtask
  task automatic pulseIo;
    ioUpdate = 1'b1;
    repeat (5) @(negedge clk);
    ioUpdate = 1'b0;
    repeat (5) @(negedge clk);
  endtask
  task automatic refEdges(input int n, input logic [15:0] want);
    logic [15:0] base;
    base = pulseCnt;
    repeat (n)
    begin
      refIn = 1'b1;
      repeat (5) @(negedge clk);
      refIn = 1'b0;
      repeat (5) @(negedge clk);
    end
    repeat (8) @(negedge clk);
    check(pulseCnt - base, want);
  endtask
  // ****************
  // Watchers
  // ****************
  always @(posedge rdValid) check({8'h00, rdByte}, {8'h00, expQ.pop_front()});
  always @(posedge clk)
  begin
    if (refDivPulse)
      pulseCnt <= pulseCnt + 16'h0001;
    // Output pin must stay off unless unidirectional, and all off in I2C mode
    if ((sdioOe && serialOutPinOe) || (!dirMode && serialOutPinOe) || (i2cMode && (sdioOe || serialOutPinOe)))
      badOe <= badOe + 16'h0001;
  end
  initial
  begin
    #600us;
    nFail++;
    final_report();
  end
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd(13'h0000, 8'h00);
    rd(13'h0004, 8'h00);
    rd2(13'h0006, 8'h00, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      ver[7:0] = rnd;
      rnd = lfsr(rnd);
      ver[15:8] = rnd;
      wr(13'h0005, ver[7:0]);
      wr(13'h0006, ver[15:8]);
      rd2(13'h0006, ver[15:8], ver[7:0]);
    end
    wr(13'h0004, 8'hFE);
    rd(13'h0004, 8'h00);
    wr(13'h0003, 8'hAA);
    rd(13'h0003, 8'h00);
    wr(13'h0010, 8'h03);
    wr(13'h0011, 8'hFE);
    rd(13'h0010, 8'h00);
    wr(13'h0004, 8'h01);
    rd2(13'h0011, 8'h02, 8'h03);
    wr(13'h0011, 8'h00);
    pulseIo();
    wr(13'h0004, 8'h00);
    rd(13'h0010, 8'h03);
    refEdges(9, 16'h0003);
    for (int d = 0; d < 2; d++)
    begin
      wr(13'h0010, d[7:0]);
      pulseIo();
      refEdges(4, 16'h0004);
    end
    wr(13'h0000, 8'h42);
    lsbMode = 1'b1;
    rd(13'h0000, 8'h42);
    rd2(13'h0005, ver[7:0], ver[15:8]);
    wr(13'h0000, 8'hC3);
    dirMode = 1'b1;
    rd(13'h0000, 8'hC3);
    rd2(13'h0005, ver[7:0], ver[15:8]);
    wr(13'h0000, 8'h24);
    lsbMode = 1'b0;
    dirMode = 1'b0;
    rd(13'h0000, 8'h00);
    rd(13'h0005, 8'h00);
    rd(13'h0010, 8'h00);
    i2cMode = 1'b1;
    repeat (5) @(negedge clk);
    wr(13'h0005, 8'h5A);
    i2cMode = 1'b0;
    repeat (5) @(negedge clk);
    rd(13'h0005, 8'h00);
    check(badOe, 16'h0000);
    check(16'(expQ.size()), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
